// *** inc/out_div_if.sv ***
interface out_div_if;
   logic [ser_cfg_pkg::MULT_BITS-1:0] mult;
   logic [ser_cfg_pkg::RDIV_BITS-1:0] rdiv;
   logic [ser_cfg_pkg::ODIV_BITS-1:0] odiv;
   logic                              run;
   logic                              bypass;
   logic                              ref_rise;
   logic                              ref_level;
   logic                              clk_out;

   modport ctrl (output mult, output rdiv, output odiv, output run, output bypass,
                 output ref_rise, output ref_level, input clk_out);
   modport div  (input mult, input rdiv, input odiv, input run, input bypass,
                 input ref_rise, input ref_level, output clk_out);
endinterface : out_div_if

// *** inc/ser_cfg_pkg.sv ***
package ser_cfg_pkg;

   // ---------------------------------------------------------------
   // configuration word
   // ---------------------------------------------------------------
   localparam int CONFIG_BITS = 160;
   localparam int COUNT_BITS  = 8;

   localparam int MULT_FIELD_BITS  = 11;
   localparam int RDIV_FIELD_BITS  = 10;
   localparam int PLL_FIELD_BITS   = 21;
   localparam int PLL_MULT_LSB     = 10;
   localparam int PLL_RDIV_LSB     = 0;

   localparam int OUT_BASE         = 84;
   localparam int OUT_FIELD_BITS   = 7;
   localparam int OUT_SEL_LSB      = 5;
   localparam int OUT_ODIV_LSB     = 0;
   localparam int SEL_BITS         = 2;
   localparam int ODIV_BITS        = 5;

   // decoded value widths: multiplier 1..2048, divider 1..1024
   localparam int MULT_BITS        = 12;
   localparam int RDIV_BITS        = 11;
   localparam int PERIOD_BITS      = 16;
   localparam int ACC_BITS         = 17;

   localparam logic [ODIV_BITS-1:0] ODIV_MIN = 5'h02;
   localparam logic [ODIV_BITS-1:0] ODIV_MAX = 5'h14;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   localparam int ADDR_BITS = 8;
   localparam int DATA_BITS = 32;
   localparam int WORD_COUNT = 5;

   localparam logic [ADDR_BITS-1:0] CONTROL_ADDR = 8'h00;
   localparam logic [ADDR_BITS-1:0] STATUS_ADDR  = 8'h04;
   localparam logic [ADDR_BITS-1:0] IMAGE0_ADDR  = 8'h10;

   localparam int CTRL_FORCE_REF_BIT = 0;
   localparam int STAT_LOADED_BIT    = 0;
   localparam int STAT_RUN_BIT       = 1;
   localparam int STAT_STROBE_BIT    = 2;
   localparam int STAT_COUNT_LSB     = 8;

endpackage : ser_cfg_pkg

// *** testbench/host_link_model.sv ***
module host_link_model (
   input  wire logic clock,
   output logic      serial_data,
   output logic      shift_clock,
   output logic      load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      serial_data = 1'b0;
      shift_clock = 1'b0;
      load_strobe = 1'b0;
   end

   task automatic send_bits(input logic [ser_cfg_pkg::CONFIG_BITS-1:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         serial_data <= w[ser_cfg_pkg::CONFIG_BITS-1-i];
         @(posedge clock);
         shift_clock <= 1'b1;
         @(posedge clock);
         shift_clock <= 1'b0;
      end
      // line inverted after the last bit: no stale copy of the last bit
      @(posedge clock);
      serial_data <= ~serial_data;
   endtask : send_bits

   task automatic set_strobe(input logic v);
      @(posedge clock);
      load_strobe <= v;
   endtask : set_strobe

   task automatic pulse_strobe;
      set_strobe(1'b1);
      repeat (4) @(posedge clock);
      load_strobe <= 1'b0;
   endtask : pulse_strobe
endmodule : host_link_model

// *** testbench/serial_config_shift_latch_assertions.sv ***
module serial_config_shift_latch_assertions #(
   parameter int OUTPUT_COUNT = 9
) (
   input wire logic                              clock,
   input wire logic                              rst,
   input wire logic                              serial_data,
   input wire logic                              shift_clock,
   input wire logic                              load_strobe,
   input wire logic                              power_down_tristate_n,
   input wire logic                              reference_input,
   input wire logic [ser_cfg_pkg::ADDR_BITS-1:0] reg_addr,
   input wire logic [ser_cfg_pkg::DATA_BITS-1:0] reg_wdata,
   input wire logic                              reg_write,
   input wire logic                              reg_read,
   input wire logic [ser_cfg_pkg::DATA_BITS-1:0] reg_rdata,
   input wire logic [OUTPUT_COUNT-1:0]           synth_output,
   input wire logic [OUTPUT_COUNT-1:0]           synth_output_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   logic       loaded_q;
   logic [1:0] settle_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         loaded_q <= 1'b0;
      end else if (load_strobe) begin
         loaded_q <= 1'b1;
      end
   end

   // pipeline from reference pin to outputs must be full before comparing
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         settle_q <= 2'h0;
      end else if (!power_down_tristate_n) begin
         settle_q <= 2'h0;
      end else if (settle_q != 2'h3) begin
         settle_q <= settle_q + 2'h1;
      end
   end

   a_pd_tristate: assert property (
      !power_down_tristate_n |=> synth_output_oe == '0 && synth_output == '0)
      else $error("outputs not off after power down");
   a_run_enable: assert property (
      !rst && power_down_tristate_n |=> synth_output_oe == '1)
      else $error("outputs not enabled while running");
   a_wake_delay: assert property (
      $rose(power_down_tristate_n) |-> synth_output_oe == '0 ##1 synth_output_oe == '1)
      else $error("wake from power down not one cycle");
   a_oe_uniform: assert property (
      synth_output_oe == '0 || synth_output_oe == '1)
      else $error("output enables differ");
   a_off_quiet: assert property (
      synth_output_oe == '0 |-> synth_output == '0)
      else $error("disabled output carries data");
   a_ref_default: assert property (
      !loaded_q && settle_q == 2'h3
         |-> synth_output == {OUTPUT_COUNT{$past(reference_input, 3)}})
      else $error("unprogrammed output not the reference");
   a_status_loaded: assert property (
      reg_read && reg_addr == ser_cfg_pkg::STATUS_ADDR
         |=> reg_rdata[ser_cfg_pkg::STAT_LOADED_BIT] == $past(loaded_q))
      else $error("loaded flag wrong");
   a_rdata_idle: assert property (
      !reg_read |=> reg_rdata == '0)
      else $error("read data without read");
endmodule : serial_config_shift_latch_assertions

// *** testbench/tb_serial_config_shift_latch.sv ***
module tb_serial_config_shift_latch;
   timeunit 1ns;
   timeprecision 1ps;

   logic                                clock;
   logic                                rst;
   logic                                serial_data;
   logic                                shift_clock;
   logic                                load_strobe;
   logic                                power_down_tristate_n;
   logic [1:0]                          ref_div_q;
   logic [ser_cfg_pkg::ADDR_BITS-1:0]   reg_addr;
   logic [ser_cfg_pkg::DATA_BITS-1:0]   reg_wdata;
   logic                                reg_write;
   logic                                reg_read;
   logic [ser_cfg_pkg::DATA_BITS-1:0]   reg_rdata;
   logic [8:0]                          synth_output;
   logic [8:0]                          synth_output_oe;
   logic [ser_cfg_pkg::CONFIG_BITS-1:0] word;
   logic [ser_cfg_pkg::CONFIG_BITS-1:0] shifted;
   int                                  mismatches;
   int                                  n_tests;

   host_link_model host_u (.clock(clock), .serial_data(serial_data),
      .shift_clock(shift_clock), .load_strobe(load_strobe));

   serial_config_shift_latch dut_u (.clock(clock), .rst(rst), .serial_data(serial_data),
      .shift_clock(shift_clock), .load_strobe(load_strobe),
      .power_down_tristate_n(power_down_tristate_n), .reference_input(ref_div_q[1]),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .synth_output(synth_output),
      .synth_output_oe(synth_output_oe));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // reference at a quarter of the system clock
   always @(posedge clock) ref_div_q <= ref_div_q + 2'h1;

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
      @(posedge clock);
      reg_addr  <= addr;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
      @(posedge clock);
      reg_addr <= addr;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 check(what, exp, reg_rdata);
   endtask : reg_rd

   // cycles between two rising edges of one output
   task automatic period_check(input int idx, input logic [31:0] exp, input string what);
      int   t0;
      int   n;
      logic prev;
      t0 = -1;
      prev = 1'b1;
      for (n = 0; n < 400; n++) begin
         @(posedge clock);
         #1;
         if (synth_output[idx] === 1'b1 && prev === 1'b0) begin
            if (t0 >= 0) break;
            t0 = n;
         end
         prev = synth_output[idx];
      end
      if (n == 400) begin
         mismatches++;
         complete_run();
      end else begin
         check(what, exp, 32'(n - t0));
      end
   endtask : period_check

   initial begin
      rst = 1'b1;
      power_down_tristate_n = 1'b1;
      ref_div_q = 2'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h00000000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      mismatches = 0;
      n_tests = 0;
      // output 1 divide 4, output 3 divide 20, others divide 0 clamped to 2, top bit marks order
      word = (160'h4 << 84) | (160'h14 << 98) | (160'h1 << 159);
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      #1 check("oe after reset", 32'h000001FF, {23'h0, synth_output_oe});
      period_check(8, 32'h00000004, "default output 9");
      period_check(0, 32'h00000004, "default output 1");
      reg_rd(ser_cfg_pkg::STATUS_ADDR, 32'h00000002, "status at start");
      reg_rd(8'hFC, 32'h00000000, "unmapped read");
      reg_wr(ser_cfg_pkg::IMAGE0_ADDR, 32'hFFFFFFFF);
      reg_rd(ser_cfg_pkg::IMAGE0_ADDR, 32'h00000000, "image read only");
      @(posedge clock);
      power_down_tristate_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1 check("oe powered down", 32'h00000000, {23'h0, synth_output_oe});
      check("data powered down", 32'h00000000, {23'h0, synth_output});
      host_u.send_bits(word, 160);
      reg_rd(ser_cfg_pkg::STATUS_ADDR, 32'h0000A000, "count of 160");
      reg_rd(8'h20, 32'h00000000, "latch holds");
      host_u.pulse_strobe();
      for (int i = 0; i < ser_cfg_pkg::WORD_COUNT; i++) begin
         reg_rd(8'(ser_cfg_pkg::IMAGE0_ADDR + 4 * i), word[32*i +: 32], "image");
      end
      reg_rd(ser_cfg_pkg::STATUS_ADDR, 32'h00000001, "loaded flag");
      @(posedge clock);
      power_down_tristate_n <= 1'b1;
      repeat (3) @(posedge clock);
      #1 check("oe running", 32'h000001FF, {23'h0, synth_output_oe});
      period_check(0, 32'h00000010, "divide 4");
      period_check(1, 32'h00000008, "divide clamped 2");
      period_check(2, 32'h00000050, "divide 20");
      reg_wr(ser_cfg_pkg::CONTROL_ADDR, 32'h00000001);
      reg_rd(ser_cfg_pkg::CONTROL_ADDR, 32'h00000001, "force reference bit");
      period_check(0, 32'h00000004, "forced reference");
      reg_wr(ser_cfg_pkg::CONTROL_ADDR, 32'h00000000);
      reg_rd(ser_cfg_pkg::CONTROL_ADDR, 32'h00000000, "force reference off");
      host_u.set_strobe(1'b1);
      host_u.send_bits({8'hFF, 152'h0}, 8);
      shifted = {word[151:0], 8'hFF};
      reg_rd(ser_cfg_pkg::IMAGE0_ADDR, shifted[31:0], "transparent low");
      reg_rd(8'h20, shifted[159:128], "transparent high");
      reg_rd(ser_cfg_pkg::STATUS_ADDR, 32'h00000007, "status strobe high");
      host_u.set_strobe(1'b0);
      complete_run();
   end
endmodule : tb_serial_config_shift_latch

bind serial_config_shift_latch serial_config_shift_latch_assertions #(
   .OUTPUT_COUNT(OUTPUT_COUNT)) chk_u (.clock(clock), .rst(rst), .serial_data(serial_data),
   .shift_clock(shift_clock), .load_strobe(load_strobe),
   .power_down_tristate_n(power_down_tristate_n), .reference_input(reference_input),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .synth_output(synth_output), .synth_output_oe(synth_output_oe));

// *** verilog/out_divider.sv ***
module out_divider (
   input  wire logic clock,
   input  wire logic rst,
   out_div_if.div    bus
);

   logic [ser_cfg_pkg::PERIOD_BITS-1:0] period;
   logic [ser_cfg_pkg::ACC_BITS-1:0]    step;
   logic [ser_cfg_pkg::ACC_BITS-1:0]    sum;
   logic [ser_cfg_pkg::ACC_BITS-1:0]    rem;
   logic [ser_cfg_pkg::ACC_BITS-1:0]    acc_q;
   logic                                level_q;

   // ---------------------------------------------------------------
   // fout = fref * mult / rdiv / odiv, capped at fref / 2
   // ---------------------------------------------------------------
   // half periods counted in units of 1/(2*mult) reference periods
   assign period = ser_cfg_pkg::PERIOD_BITS'(bus.rdiv * bus.odiv);
   assign step   = ser_cfg_pkg::ACC_BITS'({bus.mult, 1'b0});
   assign sum    = acc_q + step;
   assign rem    = sum - ser_cfg_pkg::ACC_BITS'(period);

   // accumulator keeps its phase across reprogramming, so a new
   // multiplier or divider does not restart the wave
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
      end else if (!bus.run || bus.bypass) begin
         acc_q <= '0;
      end else if (bus.ref_rise) begin
         if (sum >= ser_cfg_pkg::ACC_BITS'(period)) begin
            // limitation: toggles at most once per reference edge
            acc_q <= (rem >= ser_cfg_pkg::ACC_BITS'(period)) ? '0 : rem;
         end else begin
            acc_q <= sum;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level_q <= 1'b0;
      end else if (!bus.run) begin
         level_q <= 1'b0;
      end else if (bus.bypass) begin
         level_q <= bus.ref_level;
      end else if (bus.ref_rise && sum >= ser_cfg_pkg::ACC_BITS'(period)) begin
         level_q <= ~level_q;
      end
   end

   assign bus.clk_out = level_q;

endmodule : out_divider

// *** verilog/serial_config_shift_latch.sv ***
//
// Function
// - host shifts 160 bits, MSB first
// - load pulse after 160 bits applies word
// - load stage is level-sensitive transparent latch
// - load high: shifted bits pass straight through
// - power-down low tristates all outputs
// - raise power-down after load to run
// - unprogrammed outputs carry buffered reference clock
// - nine outputs from four selectable PLLs
// - multiplier 1..2048, divider 1..1024 per PLL
// - output divide values 2 through 20
// - fout = fref * M / N / output divide; here no higher than fref / 2, one toggle per reference edge
// - on-the-fly change, phase kept when possible
//
// Chosen here: the address map and the address-and-strobe port.
module serial_config_shift_latch #(
   parameter int OUTPUT_COUNT = 9,
   parameter int PLL_COUNT    = 4
) (
   input  wire logic                                 clock,
   input  wire logic                                 rst,
   input  wire logic                                 serial_data,
   input  wire logic                                 shift_clock,
   input  wire logic                                 load_strobe,
   input  wire logic                                 power_down_tristate_n,
   input  wire logic                                 reference_input,
   input  wire logic [ser_cfg_pkg::ADDR_BITS-1:0]    reg_addr,
   input  wire logic [ser_cfg_pkg::DATA_BITS-1:0]    reg_wdata,
   input  wire logic                                 reg_write,
   input  wire logic                                 reg_read,
   output logic      [ser_cfg_pkg::DATA_BITS-1:0]    reg_rdata,
   output logic      [OUTPUT_COUNT-1:0]              synth_output,
   output logic      [OUTPUT_COUNT-1:0]              synth_output_oe
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   localparam int PLL_END = PLL_COUNT * ser_cfg_pkg::PLL_FIELD_BITS;
   localparam int OUT_END = ser_cfg_pkg::OUT_BASE + OUTPUT_COUNT * ser_cfg_pkg::OUT_FIELD_BITS;

   generate
      if (PLL_COUNT != (1 << ser_cfg_pkg::SEL_BITS) || PLL_END > ser_cfg_pkg::OUT_BASE
          || OUT_END > ser_cfg_pkg::CONFIG_BITS || OUTPUT_COUNT < 1) begin : g_bad
         $error("output or pll count does not fit the configuration word");
      end
   endgenerate

   localparam int CB = ser_cfg_pkg::CONFIG_BITS;

   logic                                   shift_prev_q;
   logic                                   ref_prev_q;
   logic                                   ref_level_q;
   logic                                   shift_rise;
   logic                                   ref_rise;
   logic [CB-1:0]                          shift_q;
   logic [CB-1:0]                          shift_next;
   logic [CB-1:0]                          latch_q;
   logic [CB-1:0]                          latch_d;
   logic                                   loaded_q;
   logic                                   force_ref_q;
   logic [ser_cfg_pkg::COUNT_BITS-1:0]     count_q;
   logic [OUTPUT_COUNT-1:0]                div_clk;

   // ---------------------------------------------------------------
   // edge detection on the synchronous pins
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shift_prev_q <= 1'b0;
      end else begin
         shift_prev_q <= shift_clock;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ref_prev_q  <= 1'b0;
         ref_level_q <= 1'b0;
      end else begin
         ref_prev_q  <= reference_input;
         ref_level_q <= reference_input;
      end
   end

   assign shift_rise = shift_clock & ~shift_prev_q;
   assign ref_rise   = reference_input & ~ref_prev_q;

   // ---------------------------------------------------------------
   // shift register
   // ---------------------------------------------------------------
   // first bit in ends at the top once the whole word is in
   assign shift_next = {shift_q[CB-2:0], serial_data};

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shift_q <= '0;
      end else if (shift_rise) begin
         shift_q <= shift_next;
      end
   end

   // bits seen since the strobe last stood high, saturating
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (load_strobe) begin
         count_q <= '0;
      end else if (shift_rise && count_q < ser_cfg_pkg::COUNT_BITS'(CB)) begin
         count_q <= count_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // transparent load latch
   // ---------------------------------------------------------------
   // follows the shifter for as long as the strobe is high, including
   // a bit shifted in during that time; closed while it is low
   always_comb begin
      latch_d = latch_q;
      if (load_strobe) begin
         latch_d = shift_rise ? shift_next : shift_q;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         latch_q <= '0;
      end else begin
         latch_q <= latch_d;
      end
   end

   // outputs carry the reference until a word has been applied
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         loaded_q <= 1'b0;
      end else if (load_strobe) begin
         loaded_q <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // decode of the latched image
   // ---------------------------------------------------------------
   // field layout is fixed here only so that the image can drive logic
   logic [ser_cfg_pkg::MULT_BITS-1:0] pll_mult [PLL_COUNT];
   logic [ser_cfg_pkg::RDIV_BITS-1:0] pll_rdiv [PLL_COUNT];

   for (genvar p = 0; p < PLL_COUNT; p++) begin : g_pll
      localparam int BASE = p * ser_cfg_pkg::PLL_FIELD_BITS;
      // field holds value minus one, so every code is legal
      assign pll_mult[p] = {1'b0, latch_q[BASE + ser_cfg_pkg::PLL_MULT_LSB +:
                           ser_cfg_pkg::MULT_FIELD_BITS]} + 12'h001;
      assign pll_rdiv[p] = {1'b0, latch_q[BASE + ser_cfg_pkg::PLL_RDIV_LSB +:
                           ser_cfg_pkg::RDIV_FIELD_BITS]} + 11'h001;
   end

   for (genvar o = 0; o < OUTPUT_COUNT; o++) begin : g_out
      localparam int BASE = ser_cfg_pkg::OUT_BASE + o * ser_cfg_pkg::OUT_FIELD_BITS;
      logic [ser_cfg_pkg::SEL_BITS-1:0]  sel;
      logic [ser_cfg_pkg::ODIV_BITS-1:0] odiv_raw;
      logic [ser_cfg_pkg::ODIV_BITS-1:0] odiv;

      out_div_if bus ();

      assign sel      = latch_q[BASE + ser_cfg_pkg::OUT_SEL_LSB +: ser_cfg_pkg::SEL_BITS];
      assign odiv_raw = latch_q[BASE + ser_cfg_pkg::OUT_ODIV_LSB +: ser_cfg_pkg::ODIV_BITS];
      // codes outside the legal range clamp rather than stop the output
      assign odiv = (odiv_raw < ser_cfg_pkg::ODIV_MIN) ? ser_cfg_pkg::ODIV_MIN :
                    (odiv_raw > ser_cfg_pkg::ODIV_MAX) ? ser_cfg_pkg::ODIV_MAX :
                    odiv_raw;

      assign bus.mult      = pll_mult[sel];
      assign bus.rdiv      = pll_rdiv[sel];
      assign bus.odiv      = odiv;
      assign bus.run       = power_down_tristate_n;
      assign bus.bypass    = ~loaded_q | force_ref_q;
      assign bus.ref_rise  = ref_rise;
      assign bus.ref_level = ref_level_q;
      assign div_clk[o]    = bus.clk_out;

      out_divider u_div (
         .clock (clock),
         .rst   (rst),
         .bus   (bus.div)
      );
   end

   // ---------------------------------------------------------------
   // output pins
   // ---------------------------------------------------------------
   // divider state is held at zero while powered down, so the first
   // cycles after release show the word loaded meanwhile
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         synth_output    <= '0;
         synth_output_oe <= '0;
      end else if (!power_down_tristate_n) begin
         synth_output    <= '0;
         synth_output_oe <= '0;
      end else begin
         synth_output    <= div_clk;
         synth_output_oe <= '1;
      end
   end

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         force_ref_q <= 1'b0;
      end else if (reg_write && reg_addr == ser_cfg_pkg::CONTROL_ADDR) begin
         force_ref_q <= reg_wdata[ser_cfg_pkg::CTRL_FORCE_REF_BIT];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_read) begin
            if (reg_addr == ser_cfg_pkg::CONTROL_ADDR) begin
               reg_rdata[ser_cfg_pkg::CTRL_FORCE_REF_BIT] <= force_ref_q;
            end else if (reg_addr == ser_cfg_pkg::STATUS_ADDR) begin
               reg_rdata[ser_cfg_pkg::STAT_LOADED_BIT] <= loaded_q;
               reg_rdata[ser_cfg_pkg::STAT_RUN_BIT]    <= power_down_tristate_n;
               reg_rdata[ser_cfg_pkg::STAT_STROBE_BIT] <= load_strobe;
               reg_rdata[ser_cfg_pkg::STAT_COUNT_LSB +: ser_cfg_pkg::COUNT_BITS] <= count_q;
            end else begin
               for (int w = 0; w < ser_cfg_pkg::WORD_COUNT; w++) begin
                  if (reg_addr == ser_cfg_pkg::IMAGE0_ADDR + ser_cfg_pkg::ADDR_BITS'(4 * w)) begin
                     reg_rdata <= latch_q[w * ser_cfg_pkg::DATA_BITS +: ser_cfg_pkg::DATA_BITS];
                  end
               end
            end
         end
      end
   end

endmodule : serial_config_shift_latch
